// ---- dv/osc_reset_model.sv ----
// oscillator sources and external reset circuit facing the clock block
// assumes the bench steers the reset pin level through pin_low_req
`timescale 1ns/1ps
module osc_reset_model (
    // clock
    input wire logic clk,
    // bench control
    input wire logic pin_low_req,
    // enables from the block
    input wire logic fast_en,
    input wire logic slow_en,
    input wire logic ext_en,
    // sources and pin
    output logic reset_pin_n,
    output logic fast_rc_clk,
    output logic slow_rc_clk,
    output logic osc_in_pin
);
    logic [1:0] slow_div;

    // the external circuit pulls the pin low to hold reset
    assign reset_pin_n = !pin_low_req;

    initial begin
        fast_rc_clk = 1'b0;
        slow_rc_clk = 1'b0;
        osc_in_pin = 1'b0;
        slow_div = 2'h0;
    end

    // a disabled oscillator stands still, so a wrong enable stalls warm-up
    always @(posedge clk) begin
        if (fast_en) fast_rc_clk <= !fast_rc_clk;
        if (ext_en) osc_in_pin <= !osc_in_pin;
        if (slow_en) slow_div <= slow_div + 2'h1;
        if (slow_en && slow_div == 2'h3) slow_rc_clk <= !slow_rc_clk;
    end
endmodule : osc_reset_model

// ---- dv/reset_pin_and_clock_select_bench.sv ----
// self-checking bench for the reset-pin sequencer and clock selection
// assumes the oscillator model toggles the fast source every clock
`timescale 1ns/1ps
module reset_pin_and_clock_select_bench;
    import rst_clk_pkg::*;
    localparam int LIMIT = 40000;
    logic clk = 1'b0, rst_n = 1'b0, pin_low = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic wb_ack_o, reset_pin_n, fast_rc_clk, slow_rc_clk, osc_in_pin;
    logic fast_rc_enable, slow_rc_enable, ext_osc_enable, crystal_drive_en;
    logic rtc_clock_available, osc_in_gpio_en, osc_out_gpio_en;
    logic system_run, reg_init, fetch_start, cpu_tick;
    logic [13:0] fetch_addr;
    logic [31:0] rnd_state = 32'h8;
    int n_fail = 0, total_checks = 0, cycles = 0, gap, sel;

    always #2.5 clk = !clk;

    rst_clk_ctrl rst_clk_ctrl_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .reset_pin_n(reset_pin_n), .fast_rc_clk(fast_rc_clk), .slow_rc_clk(slow_rc_clk),
        .osc_in_pin(osc_in_pin), .fast_rc_enable(fast_rc_enable),
        .slow_rc_enable(slow_rc_enable), .ext_osc_enable(ext_osc_enable),
        .crystal_drive_en(crystal_drive_en), .rtc_clock_available(rtc_clock_available),
        .osc_in_gpio_en(osc_in_gpio_en), .osc_out_gpio_en(osc_out_gpio_en),
        .system_run(system_run), .reg_init(reg_init), .fetch_start(fetch_start),
        .fetch_addr(fetch_addr), .cpu_tick(cpu_tick));

    osc_reset_model osc_reset_model_i (.clk(clk), .pin_low_req(pin_low),
        .fast_en(fast_rc_enable), .slow_en(slow_rc_enable), .ext_en(ext_osc_enable),
        .reset_pin_n(reset_pin_n), .fast_rc_clk(fast_rc_clk), .slow_rc_clk(slow_rc_clk),
        .osc_in_pin(osc_in_pin));

    function automatic logic [31:0] rnd();
        rnd_state ^= rnd_state << 13;
        rnd_state ^= rnd_state >> 17;
        rnd_state ^= rnd_state << 5;
        return rnd_state;
    endfunction : rnd

    // expected {fast_rc, crystal, rtc, in_gpio, out_gpio} for a high clock choice
    function automatic logic [4:0] exp_pads(input int c);
        case (c)
            0: return 5'b10011;
            1: return 5'b11100;
            2: return 5'b00001;
            3: return 5'b01100;
            default: return 5'b01000;
        endcase
    endfunction : exp_pads

    task automatic test_done();
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    // classic cycle: hold the request until ack is sampled high
    task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd);
        int n = 0;
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        wb_sel_i <= 4'hF;
        do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) n_fail++;
    endtask : wb_xfer

    // third gap is a whole tick-to-tick interval after any option change
    task automatic tick_gap();
        for (int k = 0; k < 3; k++) begin
            gap = 0;
            do begin @(posedge clk); gap++; end while (cpu_tick !== 1'b1 && gap < 3000);
        end
    endtask : tick_gap

    // counts fast source edges from the init cycle to the first running cycle
    task automatic boot_check();
        int n = 0, edges = 0;
        logic prev = 1'b0;
        while (reg_init !== 1'b1 && n < 100) begin @(posedge clk); n++; end
        check_word(32'(reg_init), 32'h1);
        while (system_run !== 1'b1 && n < 6000) begin
            @(posedge clk);
            n++;
            if (fast_rc_clk && !prev) edges++;
            prev = fast_rc_clk;
        end
        check_word(32'(edges >= 2047 && edges <= 2049), 32'h1);
        check_word({fetch_start, 17'h0, fetch_addr}, {1'b1, 17'h0, PROGRAM_ORIGIN});
    endtask : boot_check

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            n_fail++;
            test_done();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        wb_xfer(1'b0, CTRL_OFFSET, 32'h0);
        check_word(rd, 32'h0);
        wb_xfer(1'b0, OPTION_OFFSET, 32'h0);
        check_word(rd, 32'h1);
        wb_xfer(1'b0, 4'hC, 32'h0);
        check_word(rd, 32'h0);
        wb_xfer(1'b1, CTRL_OFFSET, 32'h1);
        repeat (100) @(posedge clk);
        check_word(32'(system_run), 32'h0);
        pin_low <= 1'b0;
        boot_check();
        wb_xfer(1'b0, CTRL_OFFSET, 32'h0);
        check_word(rd, 32'h0);
        $display("test boot done");
        for (int i = 0; i < 4; i++) begin
            sel = (i == 0) ? 7 : (i == 1) ? 0 : int'(rnd() % 8);
            wb_xfer(1'b1, OPTION_OFFSET, 32'h1 | (sel << 4));
            tick_gap();
            check_word(gap, 2 << sel);
        end
        wb_xfer(1'b1, CTRL_OFFSET, 32'h1);
        for (int i = 0; i < 4; i++) begin
            wb_xfer(1'b1, OPTION_OFFSET, 32'h1 | (i << 7));
            tick_gap();
            check_word(gap, 8 << i);
        end
        wb_xfer(1'b1, CTRL_OFFSET, 32'h0);
        $display("test divide done");
        for (int c = 0; c < 6; c++) begin
            wb_xfer(1'b1, OPTION_OFFSET, 32'h1 | (c << 1));
            repeat (3) @(posedge clk);
            check_word({fast_rc_enable, crystal_drive_en, rtc_clock_available,
                osc_in_gpio_en, osc_out_gpio_en}, exp_pads(c));
        end
        wb_xfer(1'b1, OPTION_OFFSET, 32'h3);
        wb_xfer(1'b1, CTRL_OFFSET, 32'h8);
        repeat (3) @(posedge clk);
        check_word({fast_rc_enable, slow_rc_enable, crystal_drive_en, ext_osc_enable},
            4'b0011);
        wb_xfer(1'b1, OPTION_OFFSET, 32'h203);
        repeat (3) @(posedge clk);
        check_word(32'(slow_rc_enable), 32'h1);
        wb_xfer(1'b1, CTRL_OFFSET, 32'h0);
        wb_xfer(1'b1, OPTION_OFFSET, 32'h1);
        $display("test clock select done");
        @(posedge clk);
        pin_low <= 1'b1;
        gap = 0;
        do begin @(posedge clk); gap++; end while (system_run === 1'b1 && gap < 50);
        check_word(32'(gap <= 5), 32'h1);
        repeat (20) @(posedge clk);
        pin_low <= 1'b0;
        boot_check();
        pin_low <= 1'b1;
        repeat (20) @(posedge clk);
        check_word(32'(system_run), 32'h0);
        wb_xfer(1'b1, OPTION_OFFSET, 32'h0);
        boot_check();
        repeat (20) @(posedge clk);
        check_word(32'(system_run), 32'h1);
        pin_low <= 1'b0;
        $display("test pin reset done");
        test_done();
    end
endmodule : reset_pin_and_clock_select_bench

// ---- rtl/rate_divider.sv ----
// divides a source-edge enable by a power of two into the instruction tick
// assumes src_tick is a one-cycle enable synchronous to clk
`timescale 1ns/1ps
module rate_divider
    import rst_clk_pkg::*;
#(
    parameter int CNT_WIDTH = 7
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic run,
    input wire logic src_tick,
    input wire logic [2:0] rate_sel,
    // tick out
    output logic cpu_tick
);
    logic [CNT_WIDTH-1:0] count;
    wire logic [CNT_WIDTH-1:0] terminal;
    wire logic at_end;

    // wraps at width so sel 7 gives all ones, a divide by 128
    function automatic logic [CNT_WIDTH-1:0] last_count(input logic [2:0] sel);
        last_count = (CNT_WIDTH'(1) << sel) - CNT_WIDTH'(1);
    endfunction : last_count

    assign terminal = last_count(rate_sel);
    // a rate cut below the running count ends the period at once, so no period overshoots
    assign at_end = count >= terminal;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            cpu_tick <= 1'b0;
        end else if (!run) begin
            count <= '0;
            cpu_tick <= 1'b0;
        end else begin
            cpu_tick <= src_tick && at_end;
            if (src_tick) begin
                count <= at_end ? '0 : count + CNT_WIDTH'(1);
            end
        end
    end

endmodule : rate_divider

// ---- rtl/rst_clk_ctrl.sv ----
// reset-pin sequencer and system clock selection with a wishbone register port
// assumes oscillator and pin inputs are already synchronous to clk
`timescale 1ns/1ps
module rst_clk_ctrl
    import rst_clk_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // external reset pin, active low
    input wire logic reset_pin_n,
    // oscillator sources sampled as levels
    input wire logic fast_rc_clk,
    input wire logic slow_rc_clk,
    input wire logic osc_in_pin,
    // oscillator and pad control
    output logic fast_rc_enable,
    output logic slow_rc_enable,
    output logic ext_osc_enable,
    output logic crystal_drive_en,
    output logic rtc_clock_available,
    output logic osc_in_gpio_en,
    output logic osc_out_gpio_en,
    // system side
    output logic system_run,
    output logic reg_init,
    output logic fetch_start,
    output logic [13:0] fetch_addr,
    output logic cpu_tick
);

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    seq_state_type state;
    seq_state_type next_state;
    logic [3:0] ctrl;
    logic [9:0] option;
    logic pin_meta;
    logic pin_sync;
    logic fast_prev;
    logic slow_prev;
    logic osc_prev;
    logic [10:0] warm_count;

    // control and option fields
    wire logic slow_clock_select_bit = ctrl[CTRL_SLOW_BIT];
    wire logic stop_high = ctrl[CTRL_STOP_BIT];
    wire logic [1:0] cpu_mode = ctrl[CTRL_MODE_LSB +: 2];
    wire logic reset_pin_enable = option[OPT_PIN_EN_BIT];
    wire logic [2:0] high_clk_option = option[OPT_HCLK_LSB +: 3];
    wire logic [2:0] high_rate_sel = option[OPT_HSEL_LSB +: 3];
    wire logic [1:0] low_rate_sel = option[OPT_LSEL_LSB +: 2];
    wire logic wdt_always_on = option[OPT_WDT_ON_BIT];

    // source choice decode
    wire logic internal_fast_rc_only = high_clk_option == HCLK_FAST_RC_ONLY;
    wire logic internal_fast_rc_with_rtc = high_clk_option == HCLK_FAST_RC_RTC;
    wire logic internal_fast_rc = internal_fast_rc_only || internal_fast_rc_with_rtc;
    wire logic ext_rc_option = high_clk_option == HCLK_EXT_RC;
    wire logic crystal_32k_option = high_clk_option == HCLK_CRYSTAL_32K;
    wire logic crystal_option = crystal_32k_option
        || high_clk_option == HCLK_CRYSTAL_12M
        || high_clk_option == HCLK_CRYSTAL_4M;
    wire logic sleep_mode = cpu_mode == MODE_SLEEP;
    wire logic green_mode = cpu_mode == MODE_GREEN;
    wire logic rtc_green = internal_fast_rc_with_rtc && green_mode;

    // reset pin request, ignored unless the option enables the pin
    wire logic pin_reset_req = reset_pin_enable && !pin_sync;

    // source edges; inputs are synchronous so one delay suffices
    wire logic fast_edge = fast_rc_clk && !fast_prev;
    wire logic slow_edge = slow_rc_clk && !slow_prev;
    wire logic osc_edge = osc_in_pin && !osc_prev;
    wire logic hosc_edge = internal_fast_rc ? fast_edge : osc_edge;
    wire logic warm_done = hosc_edge && (warm_count == WARMUP_LAST);

    // instruction rate source
    wire logic div_src = slow_clock_select_bit ? slow_edge : hosc_edge;
    wire logic [2:0] div_sel = slow_clock_select_bit ? {1'b0, low_rate_sel}
                                                     : high_rate_sel;
    wire logic div_run = system_run && cpu_mode == MODE_NORMAL;

    // wishbone decode
    wire logic wb_req = wb_cyc_i && wb_stb_i;
    wire logic hit_ctrl = wb_adr_i == CTRL_OFFSET;
    wire logic hit_option = wb_adr_i == OPTION_OFFSET;
    wire logic hit_status = wb_adr_i == STATUS_OFFSET;
    // write lands at the edge that closes the ack cycle
    wire logic wb_write = wb_req && wb_we_i && wb_ack_o;
    wire logic [6:0] status = {ext_osc_enable, slow_rc_enable, fast_rc_enable,
                               pin_sync, system_run, state == SEQ_WARM, state == SEQ_HOLD};
    wire logic [31:0] read_word = hit_ctrl ? {28'h0000000, ctrl}
                                : hit_option ? {22'h000000, option}
                                : hit_status ? {25'h0000000, status}
                                : 32'h00000000;
    wire logic [31:0] ctrl_merged = byte_merge({28'h0000000, ctrl}, wb_dat_i, wb_sel_i);
    wire logic [31:0] option_merged = byte_merge({22'h000000, option}, wb_dat_i, wb_sel_i);

    function automatic logic [31:0] byte_merge(input logic [31:0] old_word,
                                               input logic [31:0] new_word,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_word;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_word[i*8 +: 8];
            end
        end
        byte_merge = res;
    endfunction : byte_merge

    // two flops; only pin_sync is looked at
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= reset_pin_n;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_prev <= 1'b0;
            slow_prev <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            fast_prev <= fast_rc_clk;
            slow_prev <= slow_rc_clk;
            osc_prev <= osc_in_pin;
        end
    end

    // reset sequence
    always_comb begin
        next_state = state;
        case (state)
            SEQ_HOLD: if (!pin_reset_req) next_state = SEQ_INIT;
            SEQ_INIT: next_state = SEQ_WARM;
            SEQ_WARM: if (warm_done) next_state = SEQ_RUN;
            SEQ_RUN: next_state = SEQ_RUN;
            default: next_state = SEQ_HOLD;
        endcase
        if (pin_reset_req) begin
            next_state = SEQ_HOLD;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= SEQ_HOLD;
            warm_count <= 11'h000;
            system_run <= 1'b0;
            reg_init <= 1'b0;
            fetch_start <= 1'b0;
        end else begin
            state <= next_state;
            warm_count <= (state == SEQ_WARM && hosc_edge) ? warm_count + 11'h001
                        : (state == SEQ_WARM) ? warm_count : 11'h000;
            system_run <= next_state == SEQ_RUN;
            reg_init <= next_state == SEQ_INIT;
            fetch_start <= state == SEQ_WARM && next_state == SEQ_RUN;
        end
    end

    // program counter load; holds between starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr <= PROGRAM_ORIGIN;
        end else if (state == SEQ_WARM && next_state == SEQ_RUN) begin
            fetch_addr <= PROGRAM_ORIGIN;
        end
    end

    // control is a system register and returns to default in init
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= CTRL_RESET;
        end else if (state == SEQ_INIT) begin
            ctrl <= CTRL_RESET;
        end else if (wb_write && hit_ctrl) begin
            ctrl <= ctrl_merged[3:0];
        end
    end

    // options model fixed code options, so an external reset keeps them
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            option <= OPTION_RESET;
        end else if (wb_write && hit_option) begin
            option <= option_merged[9:0];
        end
    end

    // one wait state: ack in the cycle after the request is seen
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req && !wb_ack_o;
            if (wb_req && !wb_ack_o) begin
                wb_dat_o <= read_word;
            end
        end
    end

    // oscillators and pads; registered so the pads never glitch
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_rc_enable <= 1'b0;
            slow_rc_enable <= 1'b0;
            ext_osc_enable <= 1'b0;
            crystal_drive_en <= 1'b0;
            rtc_clock_available <= 1'b0;
            osc_in_gpio_en <= 1'b0;
            osc_out_gpio_en <= 1'b0;
        end else begin
            fast_rc_enable <= internal_fast_rc && !stop_high && !sleep_mode
                              && !rtc_green;
            slow_rc_enable <= wdt_always_on
                              || (!sleep_mode && !rtc_green);
            ext_osc_enable <= internal_fast_rc_with_rtc ? !sleep_mode
                            : (ext_rc_option || crystal_option) && !stop_high && !sleep_mode;
            crystal_drive_en <= internal_fast_rc_with_rtc || crystal_option;
            rtc_clock_available <= internal_fast_rc_with_rtc || crystal_32k_option;
            osc_in_gpio_en <= internal_fast_rc_only;
            osc_out_gpio_en <= internal_fast_rc_only || ext_rc_option;
        end
    end

    rate_divider #(
        .CNT_WIDTH(7)
    ) u_rate_divider (
        .clk(clk),
        .rst_n(rst_n),
        .run(div_run),
        .src_tick(div_src),
        .rate_sel(div_sel),
        .cpu_tick(cpu_tick)
    );

    // helper: divider source edges since the last tick, high or slow clock, while running normal mode
    logic [7:0] edges_since_tick;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edges_since_tick <= 8'h00;
        end else if (!div_run || cpu_tick) begin
            edges_since_tick <= 8'h00;
        end else if (div_src && edges_since_tick != 8'hFF) begin
            edges_since_tick <= edges_since_tick + 8'h01;
        end
    end

    pin_ignore_a: assert property (state == SEQ_HOLD && !reset_pin_enable
        |=> state == SEQ_INIT) else $error("disabled reset pin held the system");
    pin_hold_a: assert property (reset_pin_enable && !pin_sync
        |=> state == SEQ_HOLD ##1 !system_run) else $error("low reset pin did not hold");
    hold_release_a: assert property (state == SEQ_HOLD && reset_pin_enable && pin_sync
        |=> state == SEQ_INIT ##0 reg_init) else $error("released pin did not start init");
    init_first_a: assert property ($rose(state == SEQ_WARM)
        |-> $past(state) == SEQ_INIT && $past(reg_init)) else $error("warm-up without init");
    warm_wait_a: assert property ($rose(system_run)
        |-> $past(state) == SEQ_WARM && $past(warm_done)) else $error("clock before warm-up");
    warm_length_a: assert property (state == SEQ_WARM && hosc_edge
        && warm_count == WARMUP_LAST - 11'h001 && !pin_reset_req ##[1:8] hosc_edge
        && warm_count == WARMUP_LAST && !pin_reset_req
        |=> system_run) else $error("warm-up not 2048 edges");
    origin_start_a: assert property (fetch_start
        |-> fetch_addr == 14'h0000 && system_run) else $error("start not at address zero");
    run_reset_a: assert property (system_run && pin_reset_req
        |=> !system_run [*2]) else $error("running system ignored reset pin");
    fast_rc_gate_a: assert property (fast_rc_enable
        |-> $past(internal_fast_rc)) else $error("fast RC on for external choice");
    pad_gpio_a: assert property (internal_fast_rc_only
        |=> osc_in_gpio_en && osc_out_gpio_en && !crystal_drive_en)
        else $error("fast RC only left pads off GPIO");
    slow_div_a: assert property (div_run && slow_clock_select_bit && low_rate_sel == 2'h3
        |-> edges_since_tick <= 8'h08) else $error("slow divide exceeded eight");
    normal_div_a: assert property (div_run && !slow_clock_select_bit
        |-> edges_since_tick <= 8'h80) else $error("normal divide exceeded 128");

    full_sequence_c: cover property (state == SEQ_HOLD ##1 state == SEQ_INIT
        ##1 state == SEQ_WARM);
    run_reset_c: cover property (system_run ##1 pin_reset_req);
    slow_tick_c: cover property (slow_clock_select_bit && cpu_tick);
    rtc_green_c: cover property (rtc_green && !fast_rc_enable && ext_osc_enable);

endmodule : rst_clk_ctrl

// ---- rtl/rst_clk_pkg.sv ----
// constants, field layout and state type for the reset-pin and clock-select block
// assumes a classic wishbone master with 32-bit data and byte-address 4-bit offsets
package rst_clk_pkg;

    // register byte offsets
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] OPTION_OFFSET = 4'h4;
    localparam logic [3:0] STATUS_OFFSET = 4'h8;

    // control register fields
    localparam int CTRL_SLOW_BIT = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int CTRL_MODE_LSB = 2;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // option register fields
    localparam int OPT_PIN_EN_BIT = 0;
    localparam int OPT_HCLK_LSB = 1;
    localparam int OPT_HSEL_LSB = 4;
    localparam int OPT_LSEL_LSB = 7;
    localparam int OPT_WDT_ON_BIT = 9;
    localparam logic [9:0] OPTION_RESET = 10'h001;

    // high-speed source choices
    localparam logic [2:0] HCLK_FAST_RC_ONLY = 3'h0;
    localparam logic [2:0] HCLK_FAST_RC_RTC = 3'h1;
    localparam logic [2:0] HCLK_EXT_RC = 3'h2;
    localparam logic [2:0] HCLK_CRYSTAL_32K = 3'h3;
    localparam logic [2:0] HCLK_CRYSTAL_12M = 3'h4;
    localparam logic [2:0] HCLK_CRYSTAL_4M = 3'h5;

    // cpu operating modes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_GREEN = 2'h2;

    // warm-up and start address
    localparam int WARMUP_CYCLES = 2048;
    localparam logic [10:0] WARMUP_LAST = 11'(WARMUP_CYCLES - 1);
    localparam logic [13:0] PROGRAM_ORIGIN = 14'h0000;

    typedef enum logic [1:0] {
        SEQ_HOLD,
        SEQ_INIT,
        SEQ_WARM,
        SEQ_RUN
    } seq_state_type;

endpackage : rst_clk_pkg
